// ---- verilog/par_prog_pkg.sv ----
// Constants and types shared by the parallel programming port
package par_prog_pkg;
    // Action codes on the two action inputs
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;
    // Command byte encodings
    localparam logic [7:0] CMD_ERASE     = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG    = 8'h08;
    localparam logic [7:0] CMD_RD_LOCKFU = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
    // Array sizes in address bits (bytes)
    localparam int FLASH_AW  = 13;
    localparam int EEPROM_AW = 9;
    localparam logic [7:0] ERASED = 8'hFF;
    // Field positions in fuse/lock data bytes
    localparam int LOCK1_WR_POS = 1;
    localparam int LOCK2_WR_POS = 2;
    localparam int SDEN_POS     = 5;
    localparam int SHORT_STARTUP_FUSE_POS    = 0;
    localparam int LOCK1_RD_POS = 7;
    localparam int LOCK2_RD_POS = 6;
    // Reset values of lock and fuse bits
    localparam logic LOCK_RST  = 1'h1;
    localparam logic SDEN_RST  = 1'h0;
    localparam logic SHORT_STARTUP_FUSE_RST = 1'h1;
    // Identification bytes, values arbitrary
    localparam logic [7:0] ID_BYTE0 = 8'h5A;
    localparam logic [7:0] ID_BYTE1 = 8'h3C;
    localparam logic [7:0] ID_BYTE2 = 8'h11;
    // Byte programming time and clock period
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS  = 700000;
    localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 18;
    // Sequencer states, binary coded from idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_BUSY  = 2'h1,
        ST_ERASE = 2'h2
    } state_t;
endpackage

// ---- verilog/byte_mem.sv ----
// Byte-wide memory array with registered read data, shipped erased
`timescale 1ns/1ps
`default_nettype none
module byte_mem #(
    parameter int AW = 9
) (
    input  wire logic          clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [7:0]    wdata_in,
    output var  logic [7:0]    rdata_out
);
    // Storage cells
    logic [7:0] mem [0:(1<<AW)-1];

    // Arrays start in the erased state
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = par_prog_pkg::ERASED;
        end
    end

    // Write port and registered read port
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule
`default_nettype wire

// ---- verilog/par_prog.sv ----
// Parallel programming sequencer for flash, EEPROM, lock and fuse bits
`timescale 1ns/1ps
`default_nettype none
module par_prog #(
    parameter int PROG_CYCLES = par_prog_pkg::PROG_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       prog_mode_in,
    input  wire logic       serial_mode_in,
    input  wire logic       crystal_input_strobe_in,
    input  wire logic       action_code_bit0_in,
    input  wire logic       action_code_bit1_in,
    input  wire logic       byte_select_in,
    input  wire logic       oe_n_in,
    input  wire logic       wr_n_in,
    input  wire logic [7:0] data_in,
    output var  logic [7:0] data_out,
    output var  logic       data_oe_out,
    output var  logic       ready_busy_out,
    output var  logic       lock_bit_one_out,
    output var  logic       lock_bit_two_out,
    output var  logic       serial_download_enable_fuse_out,
    output var  logic       short_startup_fuse_out
);
    // Whole sequencer state
    typedef struct packed {
        par_prog_pkg::state_t               st;
        logic [7:0]                         cmd;
        logic [7:0]                         addr_hi;
        logic [7:0]                         addr_lo;
        logic [7:0]                         dat_lo;
        logic [7:0]                         dat_hi;
        logic                               xtal_prev;
        logic                               wr_prev;
        logic                               lock1;
        logic                               lock2;
        logic                               sden;
        logic                               short_startup_fuse;
        logic [par_prog_pkg::TIMER_W-1:0]   timer;
        logic [par_prog_pkg::FLASH_AW-1:0]  erase_addr;
        logic [7:0]                         dout;
    } prog_state_t;

    prog_state_t state_reg;                              // Registered state
    prog_state_t state_next;                             // Next state
    logic        xtal_rise;                              // Strobe rising edge
    logic        wr_fall;                                // Write strobe falling edge
    logic        wr_lock;                                // Array/fuse writes locked
    logic        rd_lock;                                // Verify reads locked
    logic        flash_we;                               // Flash write enable
    logic        ee_we;                                  // EEPROM write enable
    logic [7:0]  mem_wdata;                              // Array write data
    logic [par_prog_pkg::FLASH_AW-1:0]  flash_addr;      // Flash byte address
    logic [par_prog_pkg::EEPROM_AW-1:0] ee_addr;         // EEPROM byte address
    logic [7:0]  flash_rdata;                            // Flash read data
    logic [7:0]  ee_rdata;                               // EEPROM read data

    // Flash array, word address plus byte select
    byte_mem #(.AW(par_prog_pkg::FLASH_AW)) flash_mem (
        .clk_in    (clk_in),
        .wr_en_in  (flash_we),
        .addr_in   (flash_addr),
        .wdata_in  (mem_wdata),
        .rdata_out (flash_rdata)
    );

    // EEPROM array
    byte_mem #(.AW(par_prog_pkg::EEPROM_AW)) eeprom_mem (
        .clk_in    (clk_in),
        .wr_en_in  (ee_we),
        .addr_in   (ee_addr),
        .wdata_in  (mem_wdata),
        .rdata_out (ee_rdata)
    );

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        xtal_rise  = prog_mode_in && crystal_input_strobe_in && !state_reg.xtal_prev;
        wr_fall    = prog_mode_in && state_reg.wr_prev && !wr_n_in;
        wr_lock    = !state_reg.lock1;
        rd_lock    = !state_reg.lock1 && !state_reg.lock2;
        flash_we   = 1'b0;
        ee_we      = 1'b0;
        mem_wdata  = byte_select_in ? state_reg.dat_hi : state_reg.dat_lo;
        flash_addr = {state_reg.addr_hi[3:0], state_reg.addr_lo, byte_select_in};
        ee_addr    = {state_reg.addr_hi[0], state_reg.addr_lo};
        state_next.xtal_prev = crystal_input_strobe_in;
        state_next.wr_prev   = wr_n_in;
        // Latch on strobe rise; latches persist across writes
        if (xtal_rise) begin
            unique case ({action_code_bit1_in, action_code_bit0_in})
                par_prog_pkg::ACT_ADDR: begin
                    if (byte_select_in) begin
                        state_next.addr_hi = data_in;
                    end else begin
                        state_next.addr_lo = data_in;
                    end
                end
                par_prog_pkg::ACT_DATA: begin
                    if (byte_select_in) begin
                        state_next.dat_hi = data_in;
                    end else begin
                        state_next.dat_lo = data_in;
                    end
                end
                par_prog_pkg::ACT_CMD: begin
                    state_next.cmd = data_in;
                end
                default: begin
                    // Idle code: nothing latched
                end
            endcase
        end
        // Sequencer
        unique case (state_reg.st)
            par_prog_pkg::ST_IDLE: begin
                if (wr_fall) begin
                    unique case (state_reg.cmd)
                        par_prog_pkg::CMD_ERASE: begin
                            state_next.st         = par_prog_pkg::ST_ERASE;
                            state_next.erase_addr = '0;
                        end
                        par_prog_pkg::CMD_WR_FLASH: begin
                            if (!wr_lock) begin
                                flash_we        = 1'b1;
                                state_next.st    = par_prog_pkg::ST_BUSY;
                                state_next.timer = '0;
                            end
                        end
                        par_prog_pkg::CMD_WR_EEPROM: begin
                            // Store overwrites, so the write self-erases
                            if (!wr_lock) begin
                                ee_we           = 1'b1;
                                state_next.st    = par_prog_pkg::ST_BUSY;
                                state_next.timer = '0;
                            end
                        end
                        par_prog_pkg::CMD_WR_LOCK: begin
                            // Locks only program; erase or system reset clears them
                            state_next.lock1 = state_reg.lock1 &
                                state_reg.dat_lo[par_prog_pkg::LOCK1_WR_POS];
                            state_next.lock2 = state_reg.lock2 &
                                state_reg.dat_lo[par_prog_pkg::LOCK2_WR_POS];
                            state_next.st    = par_prog_pkg::ST_BUSY;
                            state_next.timer = '0;
                        end
                        par_prog_pkg::CMD_WR_FUSE: begin
                            // No busy activity for fuses
                            if (!wr_lock && !serial_mode_in) begin
                                state_next.sden  =
                                    state_reg.dat_lo[par_prog_pkg::SDEN_POS];
                                state_next.short_startup_fuse =
                                    state_reg.dat_lo[par_prog_pkg::SHORT_STARTUP_FUSE_POS];
                            end
                        end
                        default: begin
                            // Read or unknown command: strobe ignored
                        end
                    endcase
                end
            end
            par_prog_pkg::ST_BUSY: begin
                // Byte programming time
                state_next.timer = state_reg.timer + 1'b1;
                if (state_reg.timer == par_prog_pkg::TIMER_W'(PROG_CYCLES - 1)) begin
                    state_next.st = par_prog_pkg::ST_IDLE;
                end
            end
            par_prog_pkg::ST_ERASE: begin
                // Sweep both arrays to all ones; fuses untouched
                flash_we   = 1'b1;
                ee_we      = state_reg.erase_addr < 13'h0200;
                mem_wdata  = par_prog_pkg::ERASED;
                flash_addr = state_reg.erase_addr;
                ee_addr    = state_reg.erase_addr[par_prog_pkg::EEPROM_AW-1:0];
                state_next.erase_addr = state_reg.erase_addr + 1'b1;
                if (&state_reg.erase_addr) begin
                    // Locks released only after full array erase
                    state_next.lock1 = par_prog_pkg::LOCK_RST;
                    state_next.lock2 = par_prog_pkg::LOCK_RST;
                    state_next.st    = par_prog_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next.st = par_prog_pkg::ST_IDLE;
            end
        endcase
        // Read data selection
        unique case (state_reg.cmd)
            par_prog_pkg::CMD_RD_FLASH:
                state_next.dout = rd_lock ? par_prog_pkg::ERASED : flash_rdata;
            par_prog_pkg::CMD_RD_EEPROM:
                state_next.dout = rd_lock ? par_prog_pkg::ERASED : ee_rdata;
            par_prog_pkg::CMD_RD_SIG: begin
                if (serial_mode_in && rd_lock && state_reg.addr_lo < 8'h03) begin
                    state_next.dout = state_reg.addr_lo;
                end else begin
                    unique case (state_reg.addr_lo)
                        8'h00:   state_next.dout = par_prog_pkg::ID_BYTE0;
                        8'h01:   state_next.dout = par_prog_pkg::ID_BYTE1;
                        8'h02:   state_next.dout = par_prog_pkg::ID_BYTE2;
                        default: state_next.dout = par_prog_pkg::ERASED;
                    endcase
                end
            end
            par_prog_pkg::CMD_RD_LOCKFU: begin
                // Reserved bits read one; fuse hidden in serial mode
                state_next.dout = par_prog_pkg::ERASED;
                state_next.dout[par_prog_pkg::LOCK1_RD_POS] = state_reg.lock1;
                state_next.dout[par_prog_pkg::LOCK2_RD_POS] = state_reg.lock2;
                state_next.dout[par_prog_pkg::SDEN_POS]     =
                    serial_mode_in ? 1'b1 : state_reg.sden;
                state_next.dout[par_prog_pkg::SHORT_STARTUP_FUSE_POS]    = state_reg.short_startup_fuse;
            end
            default:
                state_next.dout = par_prog_pkg::ERASED;
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg            <= '0;
            state_reg.st         <= par_prog_pkg::ST_IDLE;
            state_reg.wr_prev    <= 1'b1;
            state_reg.lock1      <= par_prog_pkg::LOCK_RST;
            state_reg.lock2      <= par_prog_pkg::LOCK_RST;
            state_reg.sden       <= par_prog_pkg::SDEN_RST;
            state_reg.short_startup_fuse      <= par_prog_pkg::SHORT_STARTUP_FUSE_RST;
            state_reg.dout       <= par_prog_pkg::ERASED;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign data_out        = state_reg.dout;
    assign data_oe_out     = prog_mode_in && !oe_n_in;
    assign ready_busy_out  = state_reg.st != par_prog_pkg::ST_BUSY;
    assign lock_bit_one_out                = state_reg.lock1;
    assign lock_bit_two_out                = state_reg.lock2;
    assign serial_download_enable_fuse_out = state_reg.sden;
    assign short_startup_fuse_out          = state_reg.short_startup_fuse;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_busy_on_write: assert property (
        state_reg.st == par_prog_pkg::ST_IDLE && wr_fall && !wr_lock &&
        state_reg.cmd == par_prog_pkg::CMD_WR_FLASH |=> !ready_busy_out)
        else $error("Flash write did not drop ready");
    chk_locked_no_array: assert property (
        state_reg.st != par_prog_pkg::ST_ERASE && (flash_we || ee_we) |-> state_reg.lock1)
        else $error("Array written while locked");
    chk_verify_blocked: assert property (
        (rd_lock && state_reg.cmd == par_prog_pkg::CMD_RD_FLASH) [*2] |-> data_out == 8'hFF)
        else $error("Verify read not blocked");
    chk_fuse_locked: assert property (
        wr_lock |=> $stable(state_reg.sden) && $stable(state_reg.short_startup_fuse))
        else $error("Fuse changed while locked");
    chk_erase_no_busy: assert property (
        state_reg.st == par_prog_pkg::ST_ERASE |=> ready_busy_out)
        else $error("Busy shown during erase");
    chk_lock_after_erase: assert property (
        $rose(state_reg.lock1) |-> $past(state_reg.st) == par_prog_pkg::ST_ERASE &&
        $past(&state_reg.erase_addr))
        else $error("Lock cleared before erase end");
    chk_oe_drive: assert property (
        oe_n_in |-> !data_oe_out)
        else $error("Data driven with output-enable high");
    chk_cmd_load: assert property (
        xtal_rise && {action_code_bit1_in, action_code_bit0_in} == par_prog_pkg::ACT_CMD
        |=> state_reg.cmd == $past(data_in))
        else $error("Command byte not latched");
    chk_sig_serial: assert property (
        (serial_mode_in && rd_lock && state_reg.cmd == par_prog_pkg::CMD_RD_SIG &&
        state_reg.addr_lo == 8'h01) [*2] |-> data_out == 8'h01)
        else $error("Locked serial id read wrong");
    chk_erase_fuses: assert property (
        state_reg.st == par_prog_pkg::ST_ERASE |=> $stable(state_reg.sden))
        else $error("Erase changed a fuse");

    cov_erase_done:  cover property (state_reg.st == par_prog_pkg::ST_ERASE ##1
        state_reg.st == par_prog_pkg::ST_IDLE);
    cov_flash_write: cover property ($fell(ready_busy_out) ##1 !ready_busy_out);
    cov_sig_read:    cover property (data_oe_out && state_reg.cmd == par_prog_pkg::CMD_RD_SIG);
endmodule
`default_nettype wire

// ---- dv/prog_model.sv ----
// Behavioural model of the external parallel programmer
`timescale 1ns/1ps
`default_nettype none
module prog_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] data_rd_in,
    output var  logic       mode_out,
    output var  logic       strobe_out,
    output var  logic [1:0] act_out,
    output var  logic       bs_out,
    output var  logic       oe_n_out,
    output var  logic       wr_n_out,
    output var  logic [7:0] data_out
);
    // Idle pins at time zero, action code parked on no action
    initial begin
        {mode_out, strobe_out, bs_out, oe_n_out, wr_n_out} = 5'h03;
        act_out = 2'h3;
        data_out = 8'h00;
    end
    // Entry: select low, then mode, select held still 100 ns each side
    task automatic enter();
        @(posedge clk_in) bs_out <= 1'b0;
        repeat (21) @(posedge clk_in);
        mode_out <= 1'b1;
        repeat (21) @(posedge clk_in);
    endtask
    // One positive load pulse with action code, select and data held
    task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
        @(posedge clk_in) {act_out, bs_out, data_out, strobe_out} <= {a, b, d, 1'b1};
        @(posedge clk_in) strobe_out <= 1'b0;
        @(posedge clk_in) act_out <= 2'h3;
    endtask
    // Negative write pulse, byte select driven on the same edge that drops write
    task automatic write(input logic b);
        @(posedge clk_in) {bs_out, wr_n_out} <= {b, 1'b0};
        @(posedge clk_in) wr_n_out <= 1'b1;
    endtask
    // Output-enable read; own drive is scrambled so only the device can match
    task automatic read(input logic b, output logic [7:0] v);
        @(posedge clk_in) {bs_out, oe_n_out} <= {b, 1'b0};
        data_out <= ~data_out;
        repeat (4) @(posedge clk_in);
        v = data_rd_in;
        oe_n_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- dv/parallel_memory_programming_test.sv ----
// Self-checking bench for the parallel programming sequencer
`timescale 1ns/1ps
`default_nettype none
module parallel_memory_programming_test;
    localparam int PC = 20; // Shortened byte programming time
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ser = 1'b0; // Serial mode flag
    logic mode, strobe, bs, oe_n, wr_n, doe, rdy, lk1, lk2, sdf, ssf;
    logic [1:0] act;
    logic [7:0] drv, dout, bus, v;
    int n_mismatch = 0;
    int checks_done = 0;
    int c;
    always #2.5 clk_in = ~clk_in;
    // Wire level seen by both parties
    assign bus = doe ? dout : drv;
    prog_model prog_u (.clk_in(clk_in), .data_rd_in(bus), .mode_out(mode), .strobe_out(strobe),
        .act_out(act), .bs_out(bs), .oe_n_out(oe_n), .wr_n_out(wr_n), .data_out(drv));
    par_prog #(.PROG_CYCLES(PC)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .prog_mode_in(mode), .serial_mode_in(ser), .crystal_input_strobe_in(strobe),
        .action_code_bit0_in(act[0]), .action_code_bit1_in(act[1]), .byte_select_in(bs),
        .oe_n_in(oe_n), .wr_n_in(wr_n), .data_in(bus), .data_out(dout), .data_oe_out(doe),
        .ready_busy_out(rdy), .lock_bit_one_out(lk1), .lock_bit_two_out(lk2),
        .serial_download_enable_fuse_out(sdf), .short_startup_fuse_out(ssf));
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] k);
        prog_u.load(par_prog_pkg::ACT_CMD, 1'b0, k);
    endtask
    // Address high byte first, then low byte
    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        prog_u.load(par_prog_pkg::ACT_ADDR, 1'b1, hi);
        prog_u.load(par_prog_pkg::ACT_ADDR, 1'b0, lo);
    endtask
    // Data load then write, counting busy cycles over a bounded window
    task automatic wr_byte(input logic b, input logic [7:0] d, input int lim);
        prog_u.load(par_prog_pkg::ACT_DATA, b, d);
        prog_u.write(b);
        c = 0;
        repeat (lim) begin
            #1 if (rdy !== 1'b1) c++;
            @(posedge clk_in);
        end
    endtask
    task automatic rd(input logic b, input logic [7:0] exp, input string nm);
        prog_u.read(b, v);
        chk(nm, v, exp);
    endtask
    task automatic t_reset();
        chk("ready", {7'h00, rdy}, 8'h01);
        chk("locks", {6'h00, lk1, lk2}, 8'h03);
        chk("serial fuse", {7'h00, sdf}, 8'h00);
        chk("start fuse", {7'h00, ssf}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_read_erased();
        cmd(par_prog_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            addr(8'h00, 8'(i));
            rd(1'b0, i == 0 ? par_prog_pkg::ID_BYTE0 : i == 1 ? par_prog_pkg::ID_BYTE1 :
                par_prog_pkg::ID_BYTE2, "id");
        end
        cmd(par_prog_pkg::CMD_RD_FLASH);
        addr(8'h0F, 8'hFF);
        rd(1'b0, 8'hFF, "erased lo");
        rd(1'b1, 8'hFF, "erased hi");
        // Serial fuse still programmed here, so it must read back hidden as one
        @(posedge clk_in) ser <= 1'b1;
        cmd(par_prog_pkg::CMD_RD_LOCKFU);
        rd(1'b1, 8'hFF, "hidden fuse");
        @(posedge clk_in) ser <= 1'b0;
        $display("test read erased done");
    endtask
    task automatic t_write();
        cmd(par_prog_pkg::CMD_WR_FLASH);
        addr(8'h01, 8'h23);
        wr_byte(1'b0, 8'hA5, 60);
        chk("busy lo", 8'(c), 8'(PC));
        wr_byte(1'b1, 8'h5A, 60);
        chk("busy hi", 8'(c), 8'(PC));
        cmd(par_prog_pkg::CMD_RD_FLASH);
        rd(1'b0, 8'hA5, "flash lo");
        rd(1'b1, 8'h5A, "flash hi");
        cmd(par_prog_pkg::CMD_WR_EEPROM);
        addr(8'h01, 8'h10);
        wr_byte(1'b0, 8'h3C, 60);
        chk("busy ee", 8'(c), 8'(PC));
        cmd(par_prog_pkg::CMD_RD_EEPROM);
        rd(1'b0, 8'h3C, "eeprom");
        $display("test write done");
    endtask
    task automatic t_fuse_lock();
        cmd(par_prog_pkg::CMD_WR_FUSE);
        wr_byte(1'b0, 8'hFE, 10);
        chk("fuse busy", 8'(c), 8'h00);
        chk("fuses", {6'h00, sdf, ssf}, 8'h02);
        cmd(par_prog_pkg::CMD_RD_LOCKFU);
        rd(1'b1, 8'hFE, "lock fuse byte");
        cmd(par_prog_pkg::CMD_WR_LOCK);
        wr_byte(1'b0, 8'hFD, 60);
        chk("lock one", {7'h00, lk1}, 8'h00);
        cmd(par_prog_pkg::CMD_WR_FLASH);
        addr(8'h01, 8'h23);
        wr_byte(1'b0, 8'h00, 30);
        chk("locked busy", 8'(c), 8'h00);
        cmd(par_prog_pkg::CMD_WR_FUSE);
        wr_byte(1'b0, 8'hDF, 10);
        chk("locked fuse", {7'h00, sdf}, 8'h01);
        cmd(par_prog_pkg::CMD_RD_FLASH);
        rd(1'b0, 8'hA5, "kept");
        cmd(par_prog_pkg::CMD_WR_LOCK);
        wr_byte(1'b0, 8'hFB, 60);
        cmd(par_prog_pkg::CMD_RD_FLASH);
        rd(1'b0, 8'hFF, "verify blocked");
        cmd(par_prog_pkg::CMD_RD_SIG);
        @(posedge clk_in) ser <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            addr(8'h00, 8'(i));
            rd(1'b0, 8'(i), "serial id");
        end
        @(posedge clk_in) ser <= 1'b0;
        $display("test fuse lock done");
    endtask
    // Erase wipes both arrays and releases the locks; fuses keep their values
    task automatic t_erase();
        cmd(par_prog_pkg::CMD_ERASE);
        prog_u.write(1'b0);
        c = 0;
        repeat (8300) begin
            #1 if (rdy !== 1'b1) c++;
            @(posedge clk_in);
        end
        chk("erase busy", 8'(c), 8'h00);
        chk("locks clear", {6'h00, lk1, lk2}, 8'h03);
        chk("fuses kept", {6'h00, sdf, ssf}, 8'h02);
        cmd(par_prog_pkg::CMD_RD_FLASH);
        addr(8'h01, 8'h23);
        rd(1'b1, 8'hFF, "erased flash");
        cmd(par_prog_pkg::CMD_RD_EEPROM);
        addr(8'h01, 8'h10);
        rd(1'b0, 8'hFF, "erased eeprom");
        @(posedge clk_in) ser <= 1'b1;
        cmd(par_prog_pkg::CMD_WR_FUSE);
        wr_byte(1'b0, 8'hDF, 10);
        chk("serial fuse", {7'h00, sdf}, 8'h01);
        @(posedge clk_in) ser <= 1'b0;
        $display("test erase done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        prog_u.enter();
        t_reset();
        t_read_erased();
        t_write();
        t_fuse_lock();
        t_erase();
        final_report();
    end
    // Hang limit
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
